// [core/host_bus_pkg.sv]
/*
 * Shared constants for the host write port: pin bundle layout, reset
 * levels, serial framing and the command sequencer states.
 * Assumes a single core clock; every pin is synchronised before use.
 */
package host_bus_pkg;

    // ------------------------------------------------------------------
    // Widths and buffering
    // ------------------------------------------------------------------
    localparam int BYTE_W     = 8;
    localparam int ITEM_W     = 9;
    localparam int ITEM_DC    = 8;
    localparam int FIFO_DEPTH = 4;
    localparam int BIT_CNT_W  = 3;
    localparam logic [BIT_CNT_W-1:0] BIT_LAST = 3'h7;

    // ------------------------------------------------------------------
    // Synchronised pin bundle: field positions and reset levels
    // ------------------------------------------------------------------
    localparam int PIN_W       = 13;
    localparam int PIN_DATA_LO = 0;
    localparam int PIN_SER_CLK = 6;
    localparam int PIN_SER_DAT = 7;
    localparam int PIN_MSEL    = 8;
    localparam int PIN_SSEL    = 9;
    localparam int PIN_WR      = 10;
    localparam int PIN_DC      = 11;
    localparam int PIN_PAR     = 12;
    localparam logic [PIN_W-1:0] PIN_RST = 13'h0700;

    // ------------------------------------------------------------------
    // Levels and encodings
    // ------------------------------------------------------------------
    localparam logic DC_COMMAND = 1'b0;
    localparam logic MODE_PAR   = 1'b1;
    localparam logic [5:0] SER_UNUSED = 6'h00;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

    typedef enum logic [0:0] {
        SEQ_WAIT_ADDR = 1'b0,
        SEQ_WAIT_DATA = 1'b1
    } seq_state_e;

endpackage : host_bus_pkg

// [core/host_bus_interface.sv]
/*
 * Host write port: parallel or serial byte receiver, cascade repeaters,
 * a small byte FIFO and the two-byte command sequencer.
 * Assumes all host pins are asynchronous to CORE_CLK_IN and that the
 * serial clock is slow enough (160 ns period) to be edge-sampled.
 */
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Byte FIFO
// ----------------------------------------------------------------------
module host_byte_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_in,
    input  wire logic             arst_n_in,
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    output logic                  out_valid_out,
    output logic      [WIDTH-1:0] out_data_out,
    input  wire logic             out_ready_in
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = PTR_W + 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
    logic [CNT_W-1:0] count_q, count_d;
    logic             push, pop;

    function automatic logic [PTR_W-1:0] ptr_next(logic [PTR_W-1:0] p);
        ptr_next = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : ptr_next

    assign in_ready_out  = (count_q != CNT_W'(DEPTH));
    assign out_valid_out = (count_q != '0);
    assign out_data_out  = mem[rd_ptr_q];

    always_comb begin
        push     = in_valid_in && in_ready_out;
        pop      = out_valid_out && out_ready_in;
        wr_ptr_d = push ? ptr_next(wr_ptr_q) : wr_ptr_q;
        rd_ptr_d = pop ? ptr_next(rd_ptr_q) : rd_ptr_q;
        count_d  = count_q;
        if (push && !pop) begin
            count_d = count_q + 1'b1;
        end else if (pop && !push) begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q  <= count_d;
        end
    end

    // Storage has no reset; the count keeps stale words invisible.
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data_in;
        end
    end

endmodule : host_byte_fifo

// ----------------------------------------------------------------------
// Top level
// ----------------------------------------------------------------------
module host_bus_interface (
    input  wire logic                        CORE_CLK_IN,
    input  wire logic                        ARST_N_IN,
    input  wire logic                        PAR_SEL_IN,
    input  wire logic [host_bus_pkg::BYTE_W-1:0] DATA_IN,
    input  wire logic                        MASTER_SELECT_N_IN,
    input  wire logic                        SLAVE_SELECT_N_IN,
    input  wire logic                        WRITE_STROBE_N_IN,
    input  wire logic                        DATA_OR_COMMAND_SEL_IN,
    output logic [host_bus_pkg::BYTE_W-1:0]  DATA_OUT,
    output logic                             MASTER_SELECT_REPEAT_N_OUT,
    output logic                             SLAVE_SELECT_REPEAT_N_OUT,
    output logic                             WRITE_STROBE_REPEAT_N_OUT,
    output logic                             DATA_OR_COMMAND_REPEAT_OUT,
    output logic                             OUT_VALID_OUT,
    output logic                             OUT_IS_CMD_OUT,
    output logic [host_bus_pkg::BYTE_W-1:0]  OUT_CODE_OUT,
    output logic [host_bus_pkg::BYTE_W-1:0]  OUT_DATA_OUT,
    input  wire logic                        OUT_READY_IN,
    output logic                             OVERRUN_OUT
);
    import host_bus_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [PIN_W-1:0] raw, sync1_q, sync2_q, late_q;
    logic             par_mode, both_idle, both_sel, wr_rise, sclk_rise;

    assign raw = {PAR_SEL_IN, DATA_OR_COMMAND_SEL_IN, WRITE_STROBE_N_IN,
                  SLAVE_SELECT_N_IN, MASTER_SELECT_N_IN, DATA_IN};

    // The late stage holds the level from before each detected edge, so
    // the byte taken at a strobe edge is the one set up before it.
    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            sync1_q <= PIN_RST;
            sync2_q <= PIN_RST;
            late_q  <= PIN_RST;
        end else begin
            sync1_q <= raw;
            sync2_q <= sync1_q;
            late_q  <= sync2_q;
        end
    end

    assign par_mode  = (sync2_q[PIN_PAR] == MODE_PAR);
    assign both_idle = sync2_q[PIN_MSEL] && sync2_q[PIN_SSEL];
    assign both_sel  = !sync2_q[PIN_MSEL] && !sync2_q[PIN_SSEL];
    assign wr_rise   = par_mode && both_sel
                       && sync2_q[PIN_WR] && !late_q[PIN_WR];
    assign sclk_rise = !par_mode && both_sel
                       && sync2_q[PIN_SER_CLK]
                       && !late_q[PIN_SER_CLK];

    // ------------------------------------------------------------------
    // Cascade repeaters
    // ------------------------------------------------------------------
    logic [BYTE_W-1:0] rep_data_q, rep_data_d;
    logic              rep_msel_q, rep_msel_d, rep_ssel_q, rep_ssel_d;
    logic              rep_wr_q, rep_wr_d, rep_dc_q, rep_dc_d;

    always_comb begin
        rep_msel_d = sync2_q[PIN_MSEL];
        rep_ssel_d = sync2_q[PIN_SSEL];
        rep_dc_d   = sync2_q[PIN_DC];
        if (par_mode) begin
            rep_data_d = sync2_q[PIN_DATA_LO +: BYTE_W];
            rep_wr_d   = sync2_q[PIN_WR];
        end else if (both_idle) begin
            rep_data_d = BYTE_ZERO;
            rep_wr_d   = 1'b1;
            rep_dc_d   = 1'b0;
        end else begin
            rep_data_d = {sync2_q[PIN_SER_DAT], sync2_q[PIN_SER_CLK],
                          SER_UNUSED};
            rep_wr_d   = 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            rep_data_q <= BYTE_ZERO;
            rep_msel_q <= 1'b1;
            rep_ssel_q <= 1'b1;
            rep_wr_q   <= 1'b1;
            rep_dc_q   <= 1'b0;
        end else begin
            rep_data_q <= rep_data_d;
            rep_msel_q <= rep_msel_d;
            rep_ssel_q <= rep_ssel_d;
            rep_wr_q   <= rep_wr_d;
            rep_dc_q   <= rep_dc_d;
        end
    end

    assign DATA_OUT                   = rep_data_q;
    assign MASTER_SELECT_REPEAT_N_OUT = rep_msel_q;
    assign SLAVE_SELECT_REPEAT_N_OUT  = rep_ssel_q;
    assign WRITE_STROBE_REPEAT_N_OUT  = rep_wr_q;
    assign DATA_OR_COMMAND_REPEAT_OUT = rep_dc_q;

    // ------------------------------------------------------------------
    // Byte receiver
    // ------------------------------------------------------------------
    logic [BYTE_W-2:0]    shift_q, shift_d;
    logic [BIT_CNT_W-1:0] cnt_q, cnt_d;
    logic                 overrun_q, overrun_d;
    logic                 push, fifo_in_ready;
    logic [ITEM_W-1:0]    push_item;

    always_comb begin
        shift_d   = shift_q;
        cnt_d     = cnt_q;
        push      = 1'b0;
        push_item = {late_q[PIN_DC], late_q[PIN_DATA_LO +: BYTE_W]};
        if (par_mode) begin
            push  = wr_rise;
            cnt_d = '0;
        end else if (both_idle) begin
            cnt_d = '0;
        end else if (sclk_rise) begin
            shift_d   = {shift_q[BYTE_W-3:0], late_q[PIN_SER_DAT]};
            cnt_d     = cnt_q + 1'b1;
            push      = (cnt_q == BIT_LAST);
            push_item = {late_q[PIN_DC], shift_q,
                         late_q[PIN_SER_DAT]};
        end
        // The host cannot be stalled, so a byte that meets a full FIFO
        // is dropped and reported instead.
        overrun_d = overrun_q || (push && !fifo_in_ready);
    end

    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            shift_q   <= '0;
            cnt_q     <= '0;
            overrun_q <= 1'b0;
        end else begin
            shift_q   <= shift_d;
            cnt_q     <= cnt_d;
            overrun_q <= overrun_d;
        end
    end

    assign OVERRUN_OUT = overrun_q;

    // ------------------------------------------------------------------
    // FIFO and command sequencer
    // ------------------------------------------------------------------
    logic              fifo_valid, slot_free, pop, item_cmd;
    logic [ITEM_W-1:0] fifo_item;
    seq_state_e        state_q, state_d;
    logic [BYTE_W-1:0] code_q, code_d, odata_q, odata_d, ocode_q, ocode_d;
    logic              ovalid_q, ovalid_d, ocmd_q, ocmd_d;

    host_byte_fifo #(
        .WIDTH (ITEM_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (CORE_CLK_IN),
        .arst_n_in     (ARST_N_IN),
        .in_valid_in   (push),
        .in_data_in    (push_item),
        .in_ready_out  (fifo_in_ready),
        .out_valid_out (fifo_valid),
        .out_data_out  (fifo_item),
        .out_ready_in  (slot_free)
    );

    assign slot_free = !ovalid_q || OUT_READY_IN;
    assign pop       = fifo_valid && slot_free;
    assign item_cmd  = (fifo_item[ITEM_DC] == DC_COMMAND);

    always_comb begin
        state_d  = state_q;
        code_d   = code_q;
        ovalid_d = ovalid_q && !OUT_READY_IN;
        ocmd_d   = ocmd_q;
        ocode_d  = ocode_q;
        odata_d  = odata_q;
        if (pop) begin
            case (state_q)
                SEQ_WAIT_ADDR: begin
                    if (item_cmd) begin
                        code_d  = fifo_item[BYTE_W-1:0];
                        state_d = SEQ_WAIT_DATA;
                    end
                end
                SEQ_WAIT_DATA: begin
                    state_d = SEQ_WAIT_ADDR;
                    if (item_cmd) begin
                        ovalid_d = 1'b1;
                        ocmd_d   = 1'b1;
                        ocode_d  = code_q;
                        odata_d  = fifo_item[BYTE_W-1:0];
                    end
                end
                default: state_d = SEQ_WAIT_ADDR;
            endcase
            if (!item_cmd) begin
                state_d  = SEQ_WAIT_ADDR;
                ovalid_d = 1'b1;
                ocmd_d   = 1'b0;
                ocode_d  = BYTE_ZERO;
                odata_d  = fifo_item[BYTE_W-1:0];
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            state_q  <= SEQ_WAIT_ADDR;
            code_q   <= BYTE_ZERO;
            ovalid_q <= 1'b0;
            ocmd_q   <= 1'b0;
            ocode_q  <= BYTE_ZERO;
            odata_q  <= BYTE_ZERO;
        end else begin
            state_q  <= state_d;
            code_q   <= code_d;
            ovalid_q <= ovalid_d;
            ocmd_q   <= ocmd_d;
            ocode_q  <= ocode_d;
            odata_q  <= odata_d;
        end
    end

    assign OUT_VALID_OUT  = ovalid_q;
    assign OUT_IS_CMD_OUT = ocmd_q;
    assign OUT_CODE_OUT   = ocode_q;
    assign OUT_DATA_OUT   = odata_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!ARST_N_IN);

    a_reset_idle: assert property ($rose(ARST_N_IN) |->
        state_q == SEQ_WAIT_ADDR) else $error("not idle after reset");
    a_code_waits: assert property (pop && item_cmd
        && state_q == SEQ_WAIT_ADDR |=> state_q == SEQ_WAIT_DATA
        && !$rose(ovalid_q)) else $error("code did not arm sequencer");
    a_cmd_done: assert property (pop && item_cmd
        && state_q == SEQ_WAIT_DATA |=> ovalid_q && ocmd_q
        && ocode_q == $past(code_q) && state_q == SEQ_WAIT_ADDR)
        else $error("command pair not completed");
    a_pixel_abort: assert property (pop && !item_cmd |=>
        state_q == SEQ_WAIT_ADDR && ovalid_q && !ocmd_q)
        else $error("pixel byte did not reset sequencer");
    a_par_repeat: assert property (par_mode |=>
        DATA_OUT == $past(sync2_q[PIN_DATA_LO +: BYTE_W])
        && WRITE_STROBE_REPEAT_N_OUT == $past(sync2_q[PIN_WR]))
        else $error("parallel repeat mismatch");
    a_ser_repeat: assert property (!par_mode && !both_idle |=>
        DATA_OUT == {$past(sync2_q[PIN_SER_DAT]),
                     $past(sync2_q[PIN_SER_CLK]), SER_UNUSED})
        else $error("serial repeat mismatch");
    a_ser_clear: assert property (!par_mode && both_idle |=>
        DATA_OUT == BYTE_ZERO && !DATA_OR_COMMAND_REPEAT_OUT)
        else $error("serial repeaters not cleared");
    a_par_byte: assert property (wr_rise |-> push
        && push_item == {late_q[PIN_DC], late_q[PIN_DATA_LO +: BYTE_W]})
        else $error("parallel byte not taken at strobe edge");
    a_ser_byte: assert property (sclk_rise && cnt_q == BIT_LAST |->
        push && push_item[0] == late_q[PIN_SER_DAT])
        else $error("serial byte not pushed on eighth bit");
    a_one_port: assert property (push |->
        (par_mode && wr_rise) || (!par_mode && sclk_rise))
        else $error("deselected interface accepted a write");
    a_out_hold: assert property (ovalid_q && !OUT_READY_IN |=>
        ovalid_q && $stable(odata_q)) else $error("output dropped");

    c_cmd_pair:  cover property (ovalid_q && ocmd_q);
    c_pixel:     cover property (ovalid_q && !ocmd_q);
    c_abort:     cover property (pop && !item_cmd
                                 && state_q == SEQ_WAIT_DATA);
    c_overrun:   cover property ($rose(overrun_q));

endmodule : host_bus_interface

// [testbench/host_model.sv]
/*
 * Host microcontroller model: drives the pin bundle of the write port with
 * parallel strobed writes and clocked serial bytes.
 * Assumes the core clock is on clk_in; pins change at its falling edge.
 */
`timescale 1ns/10ps

module host_model (
    input  wire logic       clk_in,
    output logic            par_sel_out,
    output logic [7:0]      data_out,
    output logic            master_select_n_out,
    output logic            slave_select_n_out,
    output logic            write_strobe_n_out,
    output logic            data_or_command_sel_out
);
    import host_bus_pkg::*;

    initial begin
        par_sel_out             = MODE_PAR;
        data_out                = BYTE_ZERO;
        master_select_n_out     = 1'b1;
        slave_select_n_out      = 1'b1;
        write_strobe_n_out      = 1'b1;
        data_or_command_sel_out = DC_COMMAND;
    end

    task automatic idle(input int n);
        repeat (n) @(negedge clk_in);
    endtask : idle

    task automatic set_pins(input logic p, input logic m, input logic s,
                            input logic [7:0] d, input logic dc);
        @(negedge clk_in);
        par_sel_out             = p;
        master_select_n_out     = m;
        slave_select_n_out      = s;
        data_out                = d;
        data_or_command_sel_out = dc;
    endtask : set_pins

    // Released data lines show the inverse so a stale byte cannot pass.
    task automatic par_write(input logic dc, input logic [7:0] b,
                             input logic m, input logic s);
        set_pins(par_sel_out, m, s, b, dc);
        write_strobe_n_out = 1'b0;
        idle(4);
        write_strobe_n_out = 1'b1;
        idle(3);
        master_select_n_out = 1'b1;
        slave_select_n_out  = 1'b1;
        data_out            = ~b;
        idle(3);
    endtask : par_write

    // Drives the write strobe alone, for cascade repeat checks.
    task automatic strobe(input logic lvl);
        @(negedge clk_in);
        write_strobe_n_out = lvl;
    endtask : strobe

    // The serial clock stands low outside a frame; data moves on its fall.
    task automatic ser_byte(input logic dc, input logic [7:0] b);
        logic [7:0] sh;
        sh = b;
        set_pins(par_sel_out, 1'b0, 1'b0, {sh[7], 1'b0, SER_UNUSED},
                 dc);
        for (int i = 0; i < BYTE_W; i++) begin
            idle(4);
            data_out[PIN_SER_CLK] = 1'b1;
            idle(4);
            sh       = sh << 1;
            data_out = {sh[7], 1'b0, SER_UNUSED};
        end
        idle(2);
        master_select_n_out   = 1'b1;
        slave_select_n_out    = 1'b1;
        data_out[PIN_SER_DAT] = ~b[0];
        idle(3);
    endtask : ser_byte
endmodule : host_model

// [testbench/host_bus_interface_tb_top.sv]
/*
 * Self-checking bench for the host write port: reset, parallel and serial
 * commands, abandoned commands, refusals, cascade repeats and overrun.
 * Assumes host_model drives the pins and this module is the consumer.
 */
`timescale 1ns/10ps

`define CHK(n, e, g) check(n, 16'(e), 16'(g))

module host_bus_interface_tb_top;
    import host_bus_pkg::*;

    logic       clk;
    logic       arst_n;
    logic       par_sel;
    logic [7:0] din;
    logic       msel_n;
    logic       ssel_n;
    logic       wr_n;
    logic       dc;
    logic [7:0] dout;
    logic       msel_rep_n;
    logic       ssel_rep_n;
    logic       wr_rep_n;
    logic       dc_rep;
    logic       out_valid;
    logic       out_is_cmd;
    logic [7:0] out_code;
    logic [7:0] out_data;
    logic       out_ready;
    logic       overrun;
    int         fails;
    int         check_count;
    int         cycles;

    host_model host (.clk_in(clk), .par_sel_out(par_sel), .data_out(din),
        .master_select_n_out(msel_n), .slave_select_n_out(ssel_n),
        .write_strobe_n_out(wr_n), .data_or_command_sel_out(dc));

    host_bus_interface dut (.CORE_CLK_IN(clk), .ARST_N_IN(arst_n),
        .PAR_SEL_IN(par_sel), .DATA_IN(din), .MASTER_SELECT_N_IN(msel_n),
        .SLAVE_SELECT_N_IN(ssel_n), .WRITE_STROBE_N_IN(wr_n),
        .DATA_OR_COMMAND_SEL_IN(dc), .DATA_OUT(dout),
        .MASTER_SELECT_REPEAT_N_OUT(msel_rep_n),
        .SLAVE_SELECT_REPEAT_N_OUT(ssel_rep_n),
        .WRITE_STROBE_REPEAT_N_OUT(wr_rep_n),
        .DATA_OR_COMMAND_REPEAT_OUT(dc_rep), .OUT_VALID_OUT(out_valid),
        .OUT_IS_CMD_OUT(out_is_cmd), .OUT_CODE_OUT(out_code),
        .OUT_DATA_OUT(out_data), .OUT_READY_IN(out_ready),
        .OVERRUN_OUT(overrun));

    // ------------------------------------------------------------------
    // Clock, reset and hang guard
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            tally_and_finish();
        end
    end

    task automatic check(input string n, input logic [15:0] e,
                         input logic [15:0] g);
        check_count++;
        if (e !== g) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish

    task automatic do_reset();
        @(negedge clk);
        arst_n = 1'b0;
        repeat (3) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask : do_reset

    // Waits for one item, compares it and accepts it with a one-cycle ready.
    task automatic expect_out(input logic c, input logic [7:0] code,
                              input logic [7:0] data);
        int k;
        for (k = 0; k < 400 && out_valid !== 1'b1; k++) @(negedge clk);
        `CHK("out_valid", 1'b1, out_valid);
        `CHK("out_is_cmd", c, out_is_cmd);
        `CHK("out_code", code, out_code);
        `CHK("out_data", data, out_data);
        out_ready = 1'b1;
        @(negedge clk);
        out_ready = 1'b0;
    endtask : expect_out

    task automatic expect_none();
        repeat (20) @(negedge clk);
        `CHK("no_output", 1'b0, out_valid);
    endtask : expect_none

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        `CHK("rst_valid", 1'b0, out_valid);
        `CHK("rst_overrun", 1'b0, overrun);
        `CHK("rst_wr_rep", 1'b1, wr_rep_n);
        `CHK("rst_sel_rep", 2'b11, {msel_rep_n, ssel_rep_n});
        $display("test reset done");
    endtask : t_reset

    task automatic t_par_cmd();
        host.par_write(DC_COMMAND, 8'hA5, 1'b0, 1'b0);
        expect_none();
        host.par_write(DC_COMMAND, 8'h3C, 1'b0, 1'b0);
        expect_out(1'b1, 8'hA5, 8'h3C);
        host.par_write(~DC_COMMAND, 8'h00, 1'b0, 1'b0);
        expect_out(1'b0, 8'h00, 8'h00);
        $display("test par_cmd done");
    endtask : t_par_cmd

    task automatic t_abort();
        host.par_write(DC_COMMAND, 8'h11, 1'b0, 1'b0);
        host.par_write(~DC_COMMAND, 8'h77, 1'b0, 1'b0);
        expect_out(1'b0, 8'h00, 8'h77);
        host.par_write(DC_COMMAND, 8'h22, 1'b0, 1'b0);
        expect_none();
        host.par_write(DC_COMMAND, 8'hFF, 1'b0, 1'b0);
        expect_out(1'b1, 8'h22, 8'hFF);
        $display("test abort done");
    endtask : t_abort

    task automatic t_refuse();
        host.par_write(DC_COMMAND, 8'h44, 1'b1, 1'b0);
        host.par_write(DC_COMMAND, 8'h55, 1'b0, 1'b1);
        expect_none();
        host.set_pins(~MODE_PAR, 1'b1, 1'b1, 8'h00, DC_COMMAND);
        host.par_write(~DC_COMMAND, 8'h66, 1'b0, 1'b0);
        expect_none();
        host.set_pins(MODE_PAR, 1'b1, 1'b1, 8'h00, DC_COMMAND);
        host.ser_byte(DC_COMMAND, 8'h12);
        host.ser_byte(DC_COMMAND, 8'h34);
        expect_none();
        $display("test refuse done");
    endtask : t_refuse

    task automatic t_repeat();
        host.set_pins(MODE_PAR, 1'b0, 1'b1, 8'h5A, 1'b1);
        host.strobe(1'b0);
        repeat (3) @(negedge clk);
        `CHK("par_dout", 8'h5A, dout);
        `CHK("par_sel_rep", 2'b01, {msel_rep_n, ssel_rep_n});
        `CHK("par_dc_rep", 1'b1, dc_rep);
        `CHK("par_wr_rep", 1'b0, wr_rep_n);
        host.strobe(1'b1);
        host.set_pins(MODE_PAR, 1'b1, 1'b0, 8'hC3, 1'b0);
        repeat (4) @(negedge clk);
        `CHK("par_dout2", 8'hC3, dout);
        `CHK("par_sel_rep2", 2'b10, {msel_rep_n, ssel_rep_n});
        host.set_pins(~MODE_PAR, 1'b0, 1'b0, 8'hBF, 1'b1);
        repeat (4) @(negedge clk);
        `CHK("ser_dout", 8'h80, dout);
        `CHK("ser_wr_rep", 1'b1, wr_rep_n);
        host.set_pins(~MODE_PAR, 1'b1, 1'b1, 8'hC0, 1'b1);
        repeat (4) @(negedge clk);
        `CHK("ser_clr_dout", 8'h00, dout);
        `CHK("ser_clr_dc", 1'b0, dc_rep);
        $display("test repeat done");
    endtask : t_repeat

    task automatic t_serial();
        host.set_pins(~MODE_PAR, 1'b1, 1'b1, 8'h00, DC_COMMAND);
        host.ser_byte(DC_COMMAND, 8'h81);
        host.ser_byte(DC_COMMAND, 8'h4E);
        expect_out(1'b1, 8'h81, 8'h4E);
        host.ser_byte(~DC_COMMAND, 8'h01);
        expect_out(1'b0, 8'h00, 8'h01);
        host.set_pins(MODE_PAR, 1'b1, 1'b1, 8'h00, DC_COMMAND);
        $display("test serial done");
    endtask : t_serial

    // The consumer stalls so the queue fills and the last two of seven bytes are dropped.
    task automatic t_overrun();
        int k;
        for (k = 0; k < 7; k++)
            host.par_write(~DC_COMMAND, 8'(8'h80 + k), 1'b0, 1'b0);
        `CHK("overrun", 1'b1, overrun);
        for (k = 0; k < 4; k++)
            expect_out(1'b0, 8'h00, 8'(8'h80 + k));
        out_ready = 1'b1;
        repeat (10) @(negedge clk);
        out_ready = 1'b0;
        `CHK("drained", 1'b0, out_valid);
        do_reset();
        `CHK("overrun_cleared", 1'b0, overrun);
        $display("test overrun done");
    endtask : t_overrun

    initial begin
        arst_n      = 1'b0;
        out_ready   = 1'b0;
        fails       = 0;
        check_count = 0;
        cycles      = 0;
        do_reset();
        t_reset();
        t_par_cmd();
        t_abort();
        t_refuse();
        t_repeat();
        t_serial();
        t_overrun();
        t_par_cmd();
        tally_and_finish();
    end
endmodule : host_bus_interface_tb_top
